// ===== rtl/audio_modulated_pulse_gen.sv
// Functional notes
// - two generators, audio or fixed duty
// - per generator four-input mixer with volumes
// - each output goes straight to a pin
// - outputs never feed back into mixers
// - mixer registers occupy 640h through 64Fh
// - bit 1 enables second generator
// - bit 0 enables first generator
// - bits 5,4 choose fixed level duty
// - level 10-bit signed, 000h half, 200h zero
// - bits 10:8 pick generator clock rate
// - higher generator clock gives a higher pulse rate, same 1024 duty steps
// - bits 14:11 pick cycle rate, some reserved
`timescale 1ns/1ns
`default_nettype none
module audio_modulated_pulse_gen
    import pulse_gen_pkg::*;
#(
    parameter int NUM_SRC = 4
) (
    input wire logic CLK_I,
    input wire logic SRST_I,
    input wire logic [15:0] REG_ADDR_I,
    input wire logic [15:0] REG_WDATA_I,
    input wire logic REG_WE_I,
    input wire logic REG_RE_I,
    output logic [15:0] REG_RDATA_O,
    input wire logic FAMILY_44K_I,
    input wire logic [4:0] RATE_TICK_I,
    input wire logic [NUM_SRC-1:0][15:0] SRC_SAMPLE_I,
    output logic PWM_A_O,
    output logic PWM_B_O
);
    reg_req_t req;
    assign req = '{addr: REG_ADDR_I, wdata: REG_WDATA_I, we: REG_WE_I, re: REG_RE_I};

    logic [15:0] drive_reg;
    logic [9:0] level_a_reg;
    logic [9:0] level_b_reg;
    mix_path_t mix_reg [0:7];
    logic [NCO_BITS:0] nco_reg;
    logic [15:0] rdata_next;

    function automatic logic [15:0] pick_src(input logic [7:0] code,
                                              input logic [NUM_SRC-1:0][15:0] s);
        logic [15:0] v;
        v = 16'h0000;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (code == 8'(i + 1)) begin
                v = s[i];
            end
        end
        return v;
    endfunction : pick_src

    // sum of four scaled paths, saturated; result is the top ten bits
    function automatic logic [9:0] mix4(input mix_path_t p0, input mix_path_t p1,
                                        input mix_path_t p2, input mix_path_t p3,
                                        input logic [NUM_SRC-1:0][15:0] s);
        logic signed [25:0] acc;
        mix_path_t p [4];
        acc = 26'sd0;
        p[0] = p0;
        p[1] = p1;
        p[2] = p2;
        p[3] = p3;
        for (int i = 0; i < 4; i++) begin
            acc = acc + ((26'($signed(pick_src(p[i].src, s)))
                          * $signed({18'h00000, p[i].vol})) >>> VOL_SHIFT);
        end
        if (acc > 26'sd32767) begin
            acc = 26'sd32767;
        end else if (acc < -26'sd32768) begin
            acc = -26'sd32768;
        end
        return acc[15:6];
    endfunction : mix4

    // decodes
    wire drive_hit = req.addr == DRIVE_CTRL_ADDR;
    wire lvl_a_hit = req.addr == LEVEL_A_ADDR;
    wire lvl_b_hit = req.addr == LEVEL_B_ADDR;
    wire mix_hit = req.addr >= MIX_BASE_ADDR && req.addr <= MIX_LAST_ADDR;
    wire [3:0] mix_off = req.addr[3:0];
    wire [2:0] clk_sel = drive_reg[CLK_SEL_LSB +: 3];
    wire [3:0] rate_sel = drive_reg[RATE_LSB +: 4];

    // reserved clock codes fall back to the lowest rate
    wire [23:0] inc_base = FAMILY_44K_I ? INC_44K : INC_48K;
    wire [23:0] nco_inc = (clk_sel == CLK_SEL_HIGH) ? 24'(inc_base << 2) :
                          (clk_sel == CLK_SEL_MID) ? 24'(inc_base << 1) : inc_base;
    wire gen_tick = nco_reg[NCO_BITS];

    // reserved rate codes give no ticks, so audio duty freezes
    wire rate_tick = (rate_sel == RATE_SYNC_1) ? RATE_TICK_I[0] :
                     (rate_sel == RATE_SYNC_2) ? RATE_TICK_I[1] :
                     (rate_sel == RATE_SYNC_3) ? RATE_TICK_I[2] :
                     (rate_sel == RATE_ASYNC_1) ? RATE_TICK_I[3] :
                     (rate_sel == RATE_ASYNC_2) ? RATE_TICK_I[4] : 1'b0;

    // mixer inputs are external samples only; the pulse outputs never loop back
    wire [9:0] mix_a = mix4(mix_reg[0], mix_reg[1], mix_reg[2], mix_reg[3],
                            SRC_SAMPLE_I);
    wire [9:0] mix_b = mix4(mix_reg[4], mix_reg[5], mix_reg[6], mix_reg[7], SRC_SAMPLE_I);

    always_comb begin
        rdata_next = 16'h0000;
        if (drive_hit) begin
            rdata_next = drive_reg;
        end else if (lvl_a_hit) begin
            rdata_next = {6'h00, level_a_reg};
        end else if (lvl_b_hit) begin
            rdata_next = {6'h00, level_b_reg};
        end else if (mix_hit) begin
            rdata_next = mix_off[0] ? {8'h00, mix_reg[mix_off[3:1]].vol}
                                    : {8'h00, mix_reg[mix_off[3:1]].src};
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            drive_reg <= 16'h0000;
            level_a_reg <= LEVEL_RESET;
            level_b_reg <= LEVEL_RESET;
        end else if (req.we) begin
            if (drive_hit) begin
                drive_reg <= {1'b0, req.wdata[14:8], 2'h0, req.wdata[5:4], 2'h0, req.wdata[1:0]};
            end
            if (lvl_a_hit) begin
                level_a_reg <= req.wdata[9:0];
            end
            if (lvl_b_hit) begin
                level_b_reg <= req.wdata[9:0];
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        for (int i = 0; i < 8; i++) begin
            if (SRST_I) begin
                mix_reg[i] <= '{src: SRC_RESET, vol: VOL_RESET};
            end else if (req.we && mix_hit && mix_off[3:1] == 3'(i)) begin
                if (mix_off[0]) begin
                    mix_reg[i].vol <= req.wdata[7:0];
                end else begin
                    mix_reg[i].src <= req.wdata[7:0];
                end
            end
        end
    end

    // carry out of the accumulator marks one generator clock period
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            nco_reg <= '0;
        end else begin
            nco_reg <= {1'b0, nco_reg[NCO_BITS-1:0]} + {1'b0, nco_inc};
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            REG_RDATA_O <= 16'h0000;
        end else if (req.re) begin
            REG_RDATA_O <= rdata_next;
        end
    end

    // core outputs are flops and go straight to the pin
    pulse_gen_core gen_a (
        .clk_i(CLK_I),
        .srst_i(SRST_I),
        .enable_i(drive_reg[ENA_A_BIT]),
        .gen_tick_i(gen_tick),
        .rate_tick_i(rate_tick),
        .fixed_i(drive_reg[FIXED_A_BIT]),
        .fixed_level_i(level_a_reg),
        .mix_level_i(mix_a),
        .pwm_o(PWM_A_O)
    );

    pulse_gen_core gen_b (
        .clk_i(CLK_I),
        .srst_i(SRST_I),
        .enable_i(drive_reg[ENA_B_BIT]),
        .gen_tick_i(gen_tick),
        .rate_tick_i(rate_tick),
        .fixed_i(drive_reg[FIXED_B_BIT]),
        .fixed_level_i(level_b_reg),
        .mix_level_i(mix_b),
        .pwm_o(PWM_B_O)
    );

    drive_readback_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (req.we && drive_hit) ##1 (req.re && drive_hit && !req.we)
        |=> REG_RDATA_O[1:0] == $past(REG_WDATA_I[1:0], 2))
        else $error("enable bits not read back");
    mix_window_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (req.re && req.addr == 16'h0650) |=> REG_RDATA_O == 16'h0000)
        else $error("address past mixer range answered");
    enable_low_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
        !drive_reg[ENA_A_BIT] [*2] |-> !PWM_A_O)
        else $error("first output active while disabled");
    reserved_rate_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (rate_sel == 4'h3) |-> !rate_tick)
        else $error("reserved rate produced a tick");
    high_clk_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (clk_sel == CLK_SEL_HIGH) |-> nco_inc == 24'(inc_base << 2))
        else $error("high clock code gave wrong step");
    rdata_hold_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
        !req.re |=> $stable(REG_RDATA_O))
        else $error("read data moved without a read");
    drive_spare_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (drive_reg & 16'h80CC) == 16'h0000)
        else $error("unused control bits set");
    tick_single_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
        gen_tick |=> !gen_tick)
        else $error("generator tick two cycles running");
endmodule : audio_modulated_pulse_gen
`default_nettype wire

// ===== rtl/pulse_gen_core.sv
`timescale 1ns/1ns
`default_nettype none
module pulse_gen_core
    import pulse_gen_pkg::*;
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic enable_i,
    input wire logic gen_tick_i,
    input wire logic rate_tick_i,
    input wire logic fixed_i,
    input wire logic [9:0] fixed_level_i,
    input wire logic [9:0] mix_level_i,
    output logic pwm_o
);
    logic [9:0] cnt_reg;
    logic [9:0] audio_duty_reg;
    wire [9:0] fixed_duty = {~fixed_level_i[9], fixed_level_i[8:0]};
    wire [9:0] mix_duty = {~mix_level_i[9], mix_level_i[8:0]};
    wire [9:0] duty = fixed_i ? fixed_duty : audio_duty_reg;
    wire pwm_next = enable_i && (cnt_reg < duty);

    always_ff @(posedge clk_i) begin
        if (srst_i || !enable_i) begin
            cnt_reg <= 10'h000;
        end else if (gen_tick_i) begin
            cnt_reg <= cnt_reg + 10'h001;
        end
    end

    // audio duty is sampled once per cycle-rate period
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            audio_duty_reg <= AUDIO_DUTY_RESET;
        end else if (rate_tick_i) begin
            audio_duty_reg <= mix_duty;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pwm_o <= 1'b0;
        end else begin
            pwm_o <= pwm_next;
        end
    end

    off_low_a: assert property (@(posedge clk_i) disable iff (srst_i)
        !enable_i |=> !pwm_o) else $error("output high while disabled");
    fixed_zero_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (enable_i && fixed_i && fixed_level_i == 10'h200) |=> !pwm_o)
        else $error("zero duty level drove output high");
    duty_latch_a: assert property (@(posedge clk_i) disable iff (srst_i)
        rate_tick_i |=> audio_duty_reg == $past(mix_duty))
        else $error("audio duty not taken at rate tick");
endmodule : pulse_gen_core
`default_nettype wire

// ===== rtl/pulse_gen_pkg.sv
package pulse_gen_pkg;

    // register indices on the 16-bit control port
    localparam logic [15:0] DRIVE_CTRL_ADDR = 16'h0030;
    localparam logic [15:0] LEVEL_A_ADDR = 16'h0031;
    localparam logic [15:0] LEVEL_B_ADDR = 16'h0032;
    localparam logic [15:0] MIX_BASE_ADDR = 16'h0640;
    localparam logic [15:0] MIX_LAST_ADDR = 16'h064F;

    // drive control field positions
    localparam int ENA_A_BIT = 0;
    localparam int ENA_B_BIT = 1;
    localparam int FIXED_A_BIT = 4;
    localparam int FIXED_B_BIT = 5;
    localparam int CLK_SEL_LSB = 8;
    localparam int RATE_LSB = 11;

    localparam logic [9:0] LEVEL_RESET = 10'h100;
    // audio duty holds 0% until the first rate tick, so an enable alone stays quiet
    localparam logic [9:0] AUDIO_DUTY_RESET = 10'h000;
    localparam logic [7:0] SRC_RESET = 8'h00;
    localparam logic [7:0] VOL_RESET = 8'h40;
    localparam int VOL_SHIFT = 6;

    localparam logic [2:0] CLK_SEL_LOW = 3'h0;
    localparam logic [2:0] CLK_SEL_MID = 3'h1;
    localparam logic [2:0] CLK_SEL_HIGH = 3'h2;

    localparam logic [3:0] RATE_SYNC_1 = 4'h0;
    localparam logic [3:0] RATE_SYNC_2 = 4'h1;
    localparam logic [3:0] RATE_SYNC_3 = 4'h2;
    localparam logic [3:0] RATE_ASYNC_1 = 4'h8;
    localparam logic [3:0] RATE_ASYNC_2 = 4'h9;

    // generator clock made by a phase accumulator on the 100 MHz clock
    localparam longint unsigned CLK_HZ = 100000000;
    localparam int NCO_BITS = 24;
    localparam longint unsigned GEN_48K_HZ = 6144000;
    localparam longint unsigned GEN_44K_HZ = 5644800;
    localparam logic [23:0] INC_48K = 24'((GEN_48K_HZ * (64'd1 << NCO_BITS)) / CLK_HZ);
    localparam logic [23:0] INC_44K = 24'((GEN_44K_HZ * (64'd1 << NCO_BITS)) / CLK_HZ);

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic we;
        logic re;
    } reg_req_t;

    typedef struct packed {
        logic [7:0] src;
        logic [7:0] vol;
    } mix_path_t;

endpackage : pulse_gen_pkg

// ===== verif/pin_load_model.sv
`timescale 1ns/1ns
`default_nettype none
// a load on a pulse output pin: adds up the cycles the pin sits high
module pin_load_model (
    input wire logic clk_i,
    input wire logic pin_i,
    input wire logic clr_i,
    output var int high_o
);
    // only a driven high counts; an unknown level never passes as on-time
    always_ff @(posedge clk_i) begin
        if (clr_i) begin
            high_o <= 0;
        end else if (pin_i === 1'b1) begin
            high_o <= high_o + 1;
        end
    end
endmodule : pin_load_model
`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import pulse_gen_pkg::*;
    // two periods at the 24.576 MHz setting, so the window phase hardly matters
    localparam int WIN = 8334;
    localparam int TOL = 12;
    logic clk, srst, we, re, clr;
    logic [15:0] addr, wdata, rdata;
    logic [4:0] tick;
    logic [3:0][15:0] smp;
    logic pwm_a, pwm_b;
    int high_a, high_b;
    int error_cnt = 0;
    int compares = 0;
    int cycles = 0;

    audio_modulated_pulse_gen #(.NUM_SRC(4)) uut (.CLK_I(clk), .SRST_I(srst),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WE_I(we), .REG_RE_I(re),
        .REG_RDATA_O(rdata), .FAMILY_44K_I(1'b0), .RATE_TICK_I(tick),
        .SRC_SAMPLE_I(smp), .PWM_A_O(pwm_a), .PWM_B_O(pwm_b));
    pin_load_model load_a (.clk_i(clk), .pin_i(pwm_a), .clr_i(clr), .high_o(high_a));
    pin_load_model load_b (.clk_i(clk), .pin_i(pwm_b), .clr_i(clr), .high_o(high_b));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 95000) begin
            error_cnt++;
            $display("[ERR] %0t run did not finish in time", $time);
            conclude();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        we = 1'b1;
        @(negedge clk);
        we = 1'b0;
    endtask : wr

    task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
        @(negedge clk);
        addr = a;
        re = 1'b1;
        @(negedge clk);
        re = 1'b0;
        check(32'(rdata), 32'(exp));
    endtask : rdc

    // write then read the same register on the very next edge
    task automatic wr_rd(input logic [15:0] a, input logic [15:0] d, input logic [15:0] exp);
        @(negedge clk);
        addr = a;
        wdata = d;
        we = 1'b1;
        @(negedge clk);
        we = 1'b0;
        re = 1'b1;
        @(negedge clk);
        re = 1'b0;
        check(32'(rdata), 32'(exp));
    endtask : wr_rd

    task automatic pulse(input int idx);
        @(negedge clk);
        tick[idx] = 1'b1;
        @(negedge clk);
        tick = 5'h00;
    endtask : pulse

    // duty codes out of 1024; the on-time over the window must match within TOL
    task automatic measure(input int duty_a, input int duty_b);
        int ea;
        int eb;
        ea = duty_a * WIN / 1024;
        eb = duty_b * WIN / 1024;
        @(negedge clk);
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        repeat (WIN - 1) @(negedge clk);
        check(32'(high_a >= ea - TOL && high_a <= ea + TOL), 32'h1);
        check(32'(high_b >= eb - TOL && high_b <= eb + TOL), 32'h1);
    endtask : measure

    initial begin
        srst = 1'b1;
        we = 1'b0;
        re = 1'b0;
        clr = 1'b0;
        addr = 16'h0000;
        wdata = 16'h0000;
        tick = 5'h00;
        smp = '0;
        repeat (3) @(negedge clk);
        srst = 1'b0;
        check(32'({pwm_a, pwm_b}), 32'h0);
        rdc(DRIVE_CTRL_ADDR, 16'h0000);
        rdc(LEVEL_A_ADDR, 16'h0100);
        rdc(LEVEL_B_ADDR, 16'h0100);
        rdc(16'h0640, 16'h0000);
        rdc(16'h064F, 16'h0040);
        rdc(16'h0033, 16'h0000);
        rdc(16'h0650, 16'h0000);
        wr_rd(DRIVE_CTRL_ADDR, 16'hFFFF, 16'h7F33);
        wr(DRIVE_CTRL_ADDR, 16'h0000);
        $display("register test done");
        wr(LEVEL_A_ADDR, 16'h0000);
        wr(LEVEL_B_ADDR, 16'h0100);
        wr(DRIVE_CTRL_ADDR, 16'h0233);
        measure(512, 768);
        wr(LEVEL_A_ADDR, 16'h01FF);
        wr(LEVEL_B_ADDR, 16'h0200);
        measure(1023, 0);
        $display("fixed level test done");
        // first generator off, second follows two mixer paths, one at half gain
        wr(DRIVE_CTRL_ADDR, 16'h0202);
        wr(16'h0648, 16'h0001);
        wr(16'h064A, 16'h0002);
        wr(16'h064B, 16'h0020);
        smp[0] = 16'h4000;
        smp[1] = 16'h4000;
        measure(0, 0);
        pulse(0);
        measure(0, 896);
        $display("audio duty test done");
        // sources go quiet and settle before the cycle rate moves
        wr(16'h0648, 16'h0000);
        wr(16'h064A, 16'h0000);
        repeat (12500) @(negedge clk);
        wr(DRIVE_CTRL_ADDR, 16'h4202);
        wr(16'h0648, 16'h0001);
        smp[0] = 16'hC000;
        pulse(0);
        measure(0, 896);
        pulse(3);
        measure(0, 256);
        $display("rate change test done");
        // reserved rate code: every tick is ignored, so the silent mix never lands
        wr(16'h0648, 16'h0000);
        repeat (12500) @(negedge clk);
        wr(DRIVE_CTRL_ADDR, 16'h1A02);
        for (int k = 0; k < 5; k++) begin
            pulse(k);
        end
        measure(0, 256);
        $display("reserved rate test done");
        conclude();
    end
endmodule : testbench
`default_nettype wire
